// >>> sfa_pkg.sv
/*
 * Package for the receive frame aligner and its status LED driver.
 * Holds state encodings, header bytes and timing constants.
 * Assumes a 10 MHz core clock and an 8-bit receive byte stream.
 */
package sfa_pkg;

	// Aligner states.
	typedef enum logic [1:0] {
		ST_SEARCH,
		ST_CHECK,
		ST_LOCK,
		ST_FLYWHEEL
	} sfa_state_e;

	// Header bytes that mark the frame start.
	localparam logic [7:0] HDR_A1 = 8'hf6;
	localparam logic [7:0] HDR_A2 = 8'h28;

	// Bytes from the A1 byte to the next frame's A1 byte (one STS-1 frame).
	localparam logic [15:0] FRAME_LEN = 16'h0366;

	// Frame period in microseconds, with checks needed and misses allowed.
	localparam int FRAME_PERIOD_US = 125;
	localparam logic [1:0] CHECK_FRAMES = 2'h3;
	localparam logic [1:0] FLY_MISSES = 2'h3;

	// Clock rate and blink timing: half period 0.4 s gives 1.25 Hz.
	localparam int CLK_HZ = 10000000;
	localparam int BLINK_HALF_MS = 400;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

	// Reset values.
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [15:0] POS_RESET = 16'h0000;
	localparam logic [31:0] CNT_RESET = 32'h00000000;

	// Bit position of the in-frame flag and the counter-run bit.
	localparam int IN_FRAME_BIT = 7;
	localparam int CNT_RUN_BIT = 7;

endpackage : sfa_pkg

// >>> sfa_led_drv.sv
/*
 * Bicolor status LED driver for one port.
 * Assumes its condition inputs are synchronous to the core clock.
 */
module sfa_led_drv
	import sfa_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Conditions.
	input wire logic i_clk_locked,
	input wire logic i_sig_det,
	input wire logic i_in_frame,
	// LED elements: bit 1 green, bit 0 red.
	output logic [1:0] o_led
);

	logic [31:0] blink_cnt_q;
	logic blink_q;

	// Slow blink phase toggles every half period.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			blink_cnt_q <= CNT_RESET;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
			blink_cnt_q <= CNT_RESET;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h00000001;
		end
	end

	// Colour choice: green, red, or both for orange; blink while unlocked.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_led <= LED_OFF;
		end else if (!i_clk_locked) begin
			o_led <= blink_q ? {i_sig_det, 1'b1} : LED_OFF;
		end else if (!i_sig_det) begin
			o_led <= 2'h1;
		end else if (!i_in_frame) begin
			o_led <= 2'h3;
		end else begin
			o_led <= 2'h2;
		end
	end

endmodule // sfa_led_drv

// >>> sfa_aligner.sv
/*
 * Receive frame aligner for one port, with its status LED.
 * Assumes byte data arrives on I_CLOCK with a valid strobe; lock and
 * signal-detect come from the line side asynchronously.
 */
// Contract
// - Hunt and lock only while framing is enabled.
// - Forward header bytes with the payload toward the host.
// - Search scans for A1 then A2; first match goes to check.
// - Three consecutive good frames in check declare lock; a miss searches.
// - Lock forwards frames and verifies header; a miss enters flywheel.
// - Three consecutive missed headers end in search; a hit returns to lock.
// - Flywheel forwards frames just like lock.
// - One bicolor LED shows clock lock, signal and framing.
// - Green all good, red signal and frame bad, orange mixed.
// - Unlocked blinks red or orange; locked shows steady red, orange, green.
// - LED blinks while clock unlocked, steady once locked.
// - In-frame flag at bit 7 set while locked.
// - Framing error counters run only while counter-run bit 7 is set.
module sfa_aligner
	import sfa_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	// Clock and reset.
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// Control.
	input wire logic I_FRAMING_EN,
	input wire logic [7:0] I_FRAME_STAT_CTRL,
	// Line status pins.
	input wire logic I_RX_CLK_LOCKED,
	input wire logic I_SIG_DET,
	// Received byte stream.
	input wire logic [7:0] I_RX_DATA,
	input wire logic I_RX_VALID,
	// Stream toward host.
	output logic [7:0] O_HOST_DATA,
	output logic O_HOST_VALID,
	output logic O_HOST_SOF,
	// Status.
	output logic [7:0] O_FRAME_STATUS,
	output logic [31:0] O_LOF_COUNT,
	output logic [31:0] O_PATTERN_ERR_COUNT,
	// LED: bit 1 green, bit 0 red.
	output logic [1:0] O_LED
);

	sfa_state_e state_q, state_d;
	logic [2:0] lock_sync_q, sig_sync_q;
	logic lock_f_q, sig_f_q;
	logic prev_a1_q;
	logic [15:0] pos_q;
	logic [1:0] cnt_q;
	logic hit, at_hdr, hunt, line_ok, run;

	// Three-stage synchronisers; a change counts once stages two and three agree.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			lock_sync_q <= 3'h0;
			sig_sync_q <= 3'h0;
			lock_f_q <= 1'b0;
			sig_f_q <= 1'b0;
		end else begin
			lock_sync_q <= {lock_sync_q[1:0], I_RX_CLK_LOCKED};
			sig_sync_q <= {sig_sync_q[1:0], I_SIG_DET};
			if (lock_sync_q[1] == lock_sync_q[2]) begin
				lock_f_q <= lock_sync_q[2];
			end
			if (sig_sync_q[1] == sig_sync_q[2]) begin
				sig_f_q <= sig_sync_q[2];
			end
		end
	end

	// Header detection and frame position.
	assign hit = I_RX_VALID && prev_a1_q && (I_RX_DATA == HDR_A2);
	assign at_hdr = I_RX_VALID && (pos_q == FRAME_LEN - 16'h0001);
	assign line_ok = lock_f_q && sig_f_q;
	assign hunt = I_FRAMING_EN && line_ok;
	assign run = I_FRAME_STAT_CTRL[CNT_RUN_BIT];

	// Remember whether the previous valid byte was A1.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			prev_a1_q <= 1'b0;
		end else if (I_RX_VALID) begin
			prev_a1_q <= (I_RX_DATA == HDR_A1);
		end
	end

	// Byte position since the A2 byte; restarts on a header found in search and at every expected header position.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			pos_q <= POS_RESET;
		end else if (state_q == ST_SEARCH && hit) begin
			pos_q <= POS_RESET;
		end else if (at_hdr) begin
			pos_q <= POS_RESET;
		end else if (I_RX_VALID) begin
			pos_q <= pos_q + 16'h0001;
		end
	end

	// Next-state logic; search moves on any header, other states at each expected header position.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SEARCH: begin
				if (hit) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (at_hdr && !hit) begin
					state_d = ST_SEARCH;
				end else if (at_hdr && cnt_q == CHECK_FRAMES - 2'h1) begin
					state_d = ST_LOCK;
				end
			end
			ST_LOCK: begin
				if (at_hdr && !hit) begin
					state_d = ST_FLYWHEEL;
				end
			end
			ST_FLYWHEEL: begin
				if (at_hdr && hit) begin
					state_d = ST_LOCK;
				end else if (at_hdr && cnt_q == FLY_MISSES - 2'h1) begin
					state_d = ST_SEARCH;
				end
			end
			default: begin
				state_d = ST_SEARCH;
			end
		endcase
	end

	// State register; disabled framing or a lost line forces search.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= ST_SEARCH;
		end else if (!hunt) begin
			state_q <= ST_SEARCH;
		end else begin
			state_q <= state_d;
		end
	end

	// Counts good frames in check and misses in flywheel.
	// The miss that leaves lock is the first of the consecutive misses,
	// so loss of frame follows the third missing header, not the fourth.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			cnt_q <= 2'h0;
		end else if (!hunt) begin
			cnt_q <= 2'h0;
		end else if (state_q == ST_LOCK && state_d == ST_FLYWHEEL) begin
			cnt_q <= 2'h1;
		end else if (state_d != state_q) begin
			cnt_q <= 2'h0;
		end else if (at_hdr && (state_q == ST_CHECK
				|| state_q == ST_FLYWHEEL)) begin
			cnt_q <= cnt_q + 2'h1;
		end
	end

	// Forward every byte, headers included, while locked or coasting.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_HOST_DATA <= 8'h00;
			O_HOST_VALID <= 1'b0;
			O_HOST_SOF <= 1'b0;
		end else begin
			O_HOST_DATA <= I_RX_DATA;
			O_HOST_VALID <= I_RX_VALID && hunt
				&& (state_q == ST_LOCK || state_q == ST_FLYWHEEL);
			O_HOST_SOF <= I_RX_VALID && hunt && prev_a1_q
				&& (I_RX_DATA == HDR_A2)
				&& (state_q == ST_LOCK || state_q == ST_FLYWHEEL);
		end
	end

	// Status byte: bit 7 in-frame, low bits show the state.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_FRAME_STATUS <= 8'h00;
		end else begin
			O_FRAME_STATUS <= 8'h00;
			O_FRAME_STATUS[IN_FRAME_BIT] <= (state_q == ST_LOCK);
			O_FRAME_STATUS[1:0] <= state_q;
		end
	end

	// Error counters run only while the counter-run bit is set.
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_LOF_COUNT <= CNT_RESET;
			O_PATTERN_ERR_COUNT <= CNT_RESET;
		end else if (run) begin
			if (hunt && state_q == ST_FLYWHEEL && state_d == ST_SEARCH) begin
				O_LOF_COUNT <= O_LOF_COUNT + 32'h00000001;
			end
			if (hunt && at_hdr && !hit && (state_q == ST_LOCK
					|| state_q == ST_FLYWHEEL)) begin
				O_PATTERN_ERR_COUNT <= O_PATTERN_ERR_COUNT + 32'h00000001;
			end
		end
	end

	// Status LED; its output is a flip-flop inside the driver.
	sfa_led_drv #(
		.BLINK_CYC(BLINK_CYC)
	) u_led (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_clk_locked(lock_f_q),
		.i_sig_det(sig_f_q),
		.i_in_frame(state_q == ST_LOCK),
		.o_led(O_LED)
	);

endmodule // sfa_aligner

// >>> sfa_aligner_chk.sv
/* Port checker for the frame aligner.
   Assumes binding to sfa_aligner on one clock. */
module sfa_aligner_chk
	import sfa_pkg::*;
#(
	parameter int BLINK_CYC = 4
) (
	// Clock, reset and inputs.
	input wire logic I_CLOCK,
	input wire logic I_RST,
	input wire logic I_FRAMING_EN,
	input wire logic [7:0] I_FRAME_STAT_CTRL,
	input wire logic I_RX_CLK_LOCKED,
	input wire logic I_SIG_DET,
	input wire logic [7:0] I_RX_DATA,
	// Outputs.
	input wire logic [7:0] O_HOST_DATA,
	input wire logic O_HOST_VALID,
	input wire logic O_HOST_SOF,
	input wire logic [7:0] O_FRAME_STATUS,
	input wire logic [31:0] O_LOF_COUNT,
	input wire logic [31:0] O_PATTERN_ERR_COUNT,
	input wire logic [1:0] O_LED
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	// Conditions that must last past the input synchronisers; run_off is on the counter-run bit, which has no synchroniser.
	sequence run_off; !I_FRAME_STAT_CTRL[7] [*3]; endsequence
	sequence no_sig; !I_SIG_DET [*8]; endsequence
	sequence red_on; (I_RX_CLK_LOCKED && !I_SIG_DET) [*8]; endsequence
	sequence dark; (!I_RX_CLK_LOCKED && !I_SIG_DET) [*8]; endsequence
	chk_host_copy: assert property (
		O_HOST_VALID |-> O_HOST_DATA == $past(I_RX_DATA)) else $error("copy");
	chk_sof_a2: assert property (
		O_HOST_SOF |-> O_HOST_VALID && O_HOST_DATA == HDR_A2) else $error("sof");
	chk_flag_lock: assert property (
		O_FRAME_STATUS[7] == (O_FRAME_STATUS[1:0] == 2'h2)) else $error("flag");
	chk_off_search: assert property (
		!I_FRAMING_EN [*3] |-> !O_FRAME_STATUS && !O_HOST_VALID)
		else $error("disable");
	chk_sig_search: assert property (
		no_sig |-> O_FRAME_STATUS == 8'h00) else $error("sig loss");
	chk_cnt_hold: assert property (
		run_off |-> $stable(O_LOF_COUNT) && $stable(O_PATTERN_ERR_COUNT))
		else $error("count hold");
	chk_lof_step: assert property (
		$changed(O_LOF_COUNT) |-> O_LOF_COUNT == $past(O_LOF_COUNT) + 32'h1)
		else $error("lof step");
	chk_led_red: assert property (
		red_on |-> O_LED == 2'h1) else $error("red");
	chk_blink_red: assert property (
		dark |-> !O_LED[1]) else $error("blink red");
	// Cycles since the LED last changed, and cycles the lock pin is low.
	logic [7:0] quiet_q, unl_q;
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			quiet_q <= 8'h00;
			unl_q <= 8'h00;
		end else begin
			quiet_q <= $changed(O_LED) ? 8'h00 : quiet_q + 8'h01;
			if (I_RX_CLK_LOCKED) begin
				unl_q <= 8'h00;
			end else if (unl_q != 8'h10) begin
				unl_q <= unl_q + 8'h01;
			end
		end
	end
	chk_blink_rate: assert property (
		unl_q == 8'h10 |-> quiet_q < BLINK_CYC) else $error("blink rate");
endmodule // sfa_aligner_chk

bind sfa_aligner sfa_aligner_chk #(.BLINK_CYC(BLINK_CYC)) u_chk (
	.I_CLOCK, .I_RST, .I_FRAMING_EN, .I_FRAME_STAT_CTRL,
	.I_RX_CLK_LOCKED, .I_SIG_DET, .I_RX_DATA, .O_HOST_DATA,
	.O_HOST_VALID, .O_HOST_SOF, .O_FRAME_STATUS, .O_LOF_COUNT,
	.O_PATTERN_ERR_COUNT, .O_LED);

// >>> sfa_line_model.sv
/* Line side model sending 870 byte frames.
   Assumes the core clock; bytes move on its rising edge. */
module sfa_line_model
	import sfa_pkg::*;
(
	// Clock and controls.
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_bad,
	// Byte stream.
	output logic [7:0] o_data = 8'h00,
	output logic o_valid = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] pos_q = 10'h000;
	// Header A1 A2 (A2 broken on request), then filler; idle data toggles.
	always_ff @(posedge i_clk) begin
		pos_q <= (!i_run || pos_q == 10'h365) ? 10'h000 : pos_q + 10'h001;
		o_valid <= i_run;
		if (!i_run)
			o_data <= ~o_data;
		else if (pos_q == 10'h000)
			o_data <= HDR_A1;
		else
			o_data <= (pos_q == 10'h001 && !i_bad) ? HDR_A2 : 8'h00;
	end
endmodule // sfa_line_model

// >>> sfa_aligner_tb.sv
/* Testbench for the frame aligner.
   Assumes the line model and a shortened blink count of 4. */
module sfa_aligner_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sfa_pkg::*;
	logic clk = 0, rst = 1, en = 0, lk = 0, sd = 0, run = 0, bad = 0;
	logic [7:0] ctl = 8'h00, rxd, hd, sts;
	logic rxv, hv, sof;
	logic [31:0] lof, pe;
	logic [1:0] led;
	int num_errors = 0, total_checks = 0, ticks = 0;
	// Clock of 100 ns and a cycle ceiling against hangs.
	always #50 clk = ~clk;
	always @(posedge clk) begin
		ticks++;
		if (ticks == 30000) begin
			num_errors++;
			end_sim();
		end
	end
	sfa_line_model line (.i_clk(clk), .i_run(run), .i_bad(bad),
		.o_data(rxd), .o_valid(rxv));
	sfa_aligner #(.BLINK_CYC(4)) uut (.I_CLOCK(clk), .I_RST(rst),
		.I_FRAMING_EN(en), .I_FRAME_STAT_CTRL(ctl), .I_RX_CLK_LOCKED(lk),
		.I_SIG_DET(sd), .I_RX_DATA(rxd), .I_RX_VALID(rxv),
		.O_HOST_DATA(hd), .O_HOST_VALID(hv), .O_HOST_SOF(sof),
		.O_FRAME_STATUS(sts), .O_LOF_COUNT(lof),
		.O_PATTERN_ERR_COUNT(pe), .O_LED(led));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic count_hv(input int n, output int c);
		c = 0;
		repeat (n) begin
			cyc(1);
			c += (hv === 1'b1);
		end
	endtask
	task automatic wait_sof;
		int i;
		i = 0;
		while (sof !== 1'b1 && i < 1000) begin
			cyc(1);
			i++;
		end
		chk(sof, 1'b1);
		chk(hd, HDR_A2);
	endtask
	// Breaks the header of n frames, starting just after a start of frame.
	task automatic bad_frames(input int n);
		wait_sof();
		bad = 1;
		cyc(870 * n + 10);
		bad = 0;
	endtask
	task automatic t_lock;
		int c;
		lk = 1;
		sd = 1;
		en = 1;
		ctl = 8'h80;
		run = 1;
		cyc(4 * 870 + 40);
		chk(sts, 8'h82);
		chk(led, 2'h2);
		wait_sof();
		count_hv(870, c);
		chk(c, 870);
		$display("t_lock done");
	endtask
	task automatic t_fly;
		logic [31:0] p0, l0;
		int c;
		p0 = pe;
		l0 = lof;
		bad_frames(1);
		chk(sts, 8'h03);
		chk(led, 2'h3);
		chk(pe, p0 + 1);
		count_hv(100, c);
		chk(c, 100);
		cyc(870);
		chk(sts, 8'h82);
		ctl = 8'h00;
		bad_frames(1);
		chk(pe, p0 + 1);
		ctl = 8'h80;
		bad_frames(3);
		chk(sts, 8'h00);
		chk(lof, l0 + 1);
		count_hv(100, c);
		chk(c, 0);
		$display("t_fly done");
	endtask
	// A header broken while checking sends the aligner back to search.
	task automatic t_check;
		int i;
		i = 0;
		while (sts !== 8'h01 && i < 1000) begin
			cyc(1);
			i++;
		end
		chk(sts, 8'h01);
		bad = 1;
		cyc(880);
		bad = 0;
		chk(sts, 8'h00);
		$display("t_check done");
	endtask
	task automatic t_loss;
		cyc(4 * 870 + 40);
		chk(sts, 8'h82);
		sd = 0;
		cyc(10);
		chk(sts, 8'h00);
		chk(led, 2'h1);
		sd = 1;
		en = 0;
		cyc(4 * 870 + 40);
		chk(sts, 8'h00);
		$display("t_loss done");
	endtask
	task automatic t_blink;
		int n;
		lk = 0;
		for (int s = 0; s < 2; s++) begin
			sd = s[0];
			cyc(10);
			n = 0;
			repeat (40) begin
				cyc(1);
				n += (led === (s ? 2'h3 : 2'h1));
			end
			chk(n, 20);
		end
		$display("t_blink done");
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset for 16 cycles, then the scenarios in turn.
	initial begin
		repeat (16) @(posedge clk);
		#5;
		rst = 0;
		t_lock();
		t_fly();
		t_check();
		t_loss();
		t_blink();
		end_sim();
	end
endmodule // sfa_aligner_tb
